// file: common/ssfid_pkg.sv
// Shared types and constants of the SIMD single-float/integer datapath
`default_nettype none
package ssfid_pkg;

  // Widths
  localparam int LANE_W = 32;
  localparam int LANES = 4;
  localparam int VEC_W = 128;
  localparam int CSR_W = 32;

  // Control/status register value after reset and rounding field position
  localparam logic [31:0] CSR_RESET = 32'h0000_0000;
  localparam int CSR_RC_LSB = 13;

  // Rounding control encodings
  localparam logic [1:0] RC_NEAREST = 2'h0;
  localparam logic [1:0] RC_DOWN = 2'h1;
  localparam logic [1:0] RC_UP = 2'h2;
  localparam logic [1:0] RC_ZERO = 2'h3;

  // Compare predicate encodings, immediate bits 2:0
  localparam logic [2:0] PRED_EQ = 3'h0;
  localparam logic [2:0] PRED_LT = 3'h1;
  localparam logic [2:0] PRED_LE = 3'h2;
  localparam logic [2:0] PRED_UNORD = 3'h3;
  localparam logic [2:0] PRED_NEQ = 3'h4;
  localparam logic [2:0] PRED_NLT = 3'h5;
  localparam logic [2:0] PRED_NLE = 3'h6;
  localparam logic [2:0] PRED_ORD = 3'h7;

  // Float format constants
  localparam logic [7:0] F_BIAS = 8'h7f;
  localparam logic [7:0] F2I_E_UNIT = 8'h96;
  localparam logic [7:0] F2I_E_LIMIT = 8'h9e;
  localparam logic [31:0] INT_INDEFINITE = 32'h8000_0000;
  localparam logic [30:0] NEG_2P31_MAG = 31'h4f00_0000;

  // Operations
  typedef enum logic [4:0] {
    OP_NOP,
    OP_CMP_PACKED_SINGLE,
    OP_CMP_SCALAR_SINGLE,
    OP_ORDERED_CMP_FLAGS,
    OP_UNORDERED_CMP_FLAGS,
    OP_SHUFFLE_PACKED_SINGLE,
    OP_UNPACK_HIGH_SINGLE,
    OP_UNPACK_LOW_SINGLE,
    OP_CVT_PACKED_INT_TO_SINGLE,
    OP_CVT_INT_TO_SCALAR_SINGLE,
    OP_CVT_PACKED_SINGLE_TO_INT,
    OP_CVT_TRUNC_PACKED_SINGLE_TO_INT,
    OP_CVT_SCALAR_SINGLE_TO_INT,
    OP_CVT_TRUNC_SCALAR_SINGLE_TO_INT,
    OP_AVG_UNSIGNED_BYTE,
    OP_AVG_UNSIGNED_WORD,
    OP_EXTRACT_WORD,
    OP_INSERT_WORD,
    OP_MAX_UNSIGNED_BYTE,
    OP_MIN_UNSIGNED_BYTE,
    OP_MAX_SIGNED_WORD,
    OP_MIN_SIGNED_WORD,
    OP_BYTE_SIGN_MASK,
    OP_MUL_HIGH_UNSIGNED_WORD,
    OP_SUM_ABS_DIFF_BYTE,
    OP_SHUFFLE_WORD,
    OP_LOAD_VECTOR_CSR,
    OP_STORE_VECTOR_CSR
  } ssfid_op_t;

  // Processor flag subset
  typedef struct packed {
    logic zero_flag;
    logic parity_flag;
    logic carry_flag;
  } ssfid_flags_t;

  // Issue request
  typedef struct packed {
    ssfid_op_t op;
    logic [7:0] imm;
    logic wide;
    logic [VEC_W-1:0] dst;
    logic [VEC_W-1:0] src;
    logic [31:0] gpr;
    logic [31:0] mem;
  } ssfid_req_t;

  // Writeback answer
  typedef struct packed {
    logic [VEC_W-1:0] vec;
    logic [31:0] gpr;
    ssfid_flags_t flags;
    logic invalid;
    logic vec_we;
    logic gpr_we;
    logic flags_we;
    logic mem_we;
    logic [31:0] mem_data;
  } ssfid_resp_t;

  // Rounding increment from mode, sign, lsb, guard and sticky
  function automatic logic round_up(input logic [1:0] mode,
                                    input logic sign, input logic lsb,
                                    input logic g, input logic s);
    case (mode)
      RC_NEAREST: round_up = g & (s | lsb);
      RC_DOWN: round_up = sign & (g | s);
      RC_UP: round_up = ~sign & (g | s);
      default: round_up = 1'b0;
    endcase
  endfunction : round_up

endpackage : ssfid_pkg
`default_nettype wire

// file: core/ssfid_fcmp.sv
// Single-precision lane comparator
`default_nettype none
module ssfid_fcmp (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // Relations
  output logic lt,
  output logic eq,
  output logic unord,
  output logic snan
);
  logic nan_a;
  logic nan_b;
  logic zero_both;
  logic mag_lt;
  logic mag_eq;

  // Sign-magnitude ordering; both zeros compare equal
  always_comb begin
    nan_a = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
    nan_b = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
    zero_both = (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
    mag_lt = a[30:0] < b[30:0];
    mag_eq = a[30:0] == b[30:0];
    unord = nan_a | nan_b;
    snan = (nan_a & ~a[22]) | (nan_b & ~b[22]); // Quiet bit clear
    eq = ~unord & (zero_both | (mag_eq & (a[31] == b[31])));
    if (unord || zero_both) begin
      lt = 1'b0;
    end else if (a[31] != b[31]) begin
      lt = a[31];
    end else if (a[31]) begin
      lt = ~mag_lt & ~mag_eq; // Negative: larger magnitude is less
    end else begin
      lt = mag_lt;
    end
  end
endmodule : ssfid_fcmp
`default_nettype wire

// file: core/ssfid_fcvt.sv
// Single-precision to/from signed doubleword lane converter
`default_nettype none
module ssfid_fcvt (
  // Control
  input wire logic to_int,
  input wire logic [1:0] mode,
  // Data
  input wire logic [31:0] x,
  output logic [31:0] y,
  output logic invalid
);
  import ssfid_pkg::*;
  logic sign;
  logic [7:0] e;
  logic [23:0] m;
  logic [63:0] t;
  logic far;
  logic inc;
  logic [32:0] mag;
  logic [31:0] ival;
  logic [4:0] msb;
  logic [31:0] norm;
  logic [24:0] mr;
  logic [7:0] ex;

  // Both directions share the rounding decision
  always_comb begin
    sign = x[31];
    e = x[30:23];
    m = {e != 8'h0, x[22:0]};
    t = 64'h0;
    far = 1'b0;
    inc = 1'b0;
    mag = 33'h0;
    ival = 32'h0;
    msb = 5'h0;
    norm = 32'h0;
    mr = 25'h0;
    ex = 8'h0;
    y = 32'h0;
    invalid = 1'b0;
    if (to_int) begin
      if (e >= F2I_E_LIMIT) begin
        // NaN, infinity and out of range give the indefinite integer
        y = INT_INDEFINITE;
        invalid = ~(sign && x[30:0] == NEG_2P31_MAG);
      end else begin
        // Fixed point with 32 fraction bits
        if (e >= F2I_E_UNIT) begin
          t = {8'h0, m, 32'h0} << (e - F2I_E_UNIT);
        end else if ((F2I_E_UNIT - e) > 8'h3f) begin
          far = |m; // Entire value shifted past the sticky window
        end else begin
          t = {8'h0, m, 32'h0} >> (F2I_E_UNIT - e);
        end
        inc = round_up(mode, sign, t[32], t[31], (|t[30:0]) | far);
        mag = {1'b0, t[63:32]} + {32'h0, inc};
        if (sign ? (mag > 33'h0_8000_0000) : (mag >= 33'h0_8000_0000)) begin
          y = INT_INDEFINITE;
          invalid = 1'b1;
        end else begin
          y = sign ? (32'h0 - mag[31:0]) : mag[31:0];
        end
      end
    end else begin
      ival = sign ? (32'h0 - x) : x;
      if (ival != 32'h0) begin
        for (int i = 0; i < 32; i++) begin
          if (ival[i]) begin
            msb = 5'(i);
          end
        end
        norm = ival << (5'd31 - msb);
        inc = round_up(mode, sign, norm[8], norm[7], |norm[6:0]);
        mr = {1'b0, norm[31:8]} + {24'h0, inc};
        // Mantissa carry out bumps the exponent
        ex = F_BIAS + {3'h0, msb} + {7'h0, mr[24]};
        y = {sign, ex, mr[24] ? 23'h0 : mr[22:0]};
      end
    end
  end
endmodule : ssfid_fcvt
`default_nettype wire

// file: core/ssfid_datapath.sv
// Top of the SIMD single-float and packed-integer execution datapath
`default_nettype none
module ssfid_datapath (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Issue side
  input wire logic REQ_VALID,
  input wire ssfid_pkg::ssfid_req_t REQ,
  // Writeback side
  output logic RESP_VALID,
  output var ssfid_pkg::ssfid_resp_t RESP,
  // Control/status register contents
  output logic [ssfid_pkg::CSR_W-1:0] CSR_VALUE
);
  import ssfid_pkg::*;

  logic [VEC_W-1:0] d;
  logic [VEC_W-1:0] s;
  logic [LANES-1:0] lane_lt;
  logic [LANES-1:0] lane_eq;
  logic [LANES-1:0] lane_un;
  logic [LANES-1:0] lane_sn;
  logic [1:0][31:0] cvt_in;
  logic [1:0][31:0] cvt_out;
  logic [1:0] cvt_inv;
  logic cvt_to_int;
  logic cvt_trunc;
  logic [1:0] cvt_mode;
  ssfid_resp_t resp_reg;
  ssfid_resp_t resp_next;
  logic valid_reg;
  logic valid_next;
  logic [CSR_W-1:0] csr_reg;
  logic [CSR_W-1:0] csr_next;
  logic keep_hi;
  logic [2:0] idx;
  logic [8:0] s9;
  logic [16:0] s17;
  logic [31:0] prod;
  logic [15:0] mask;
  logic [7:0] ab;
  logic [7:0] bb;
  logic [10:0] acc0;
  logic [10:0] acc1;

  assign d = REQ.dst;
  assign s = REQ.src;

  // Predicate decode shared by packed and scalar compares
  function automatic logic pred_hit(input logic [2:0] p, input logic lt,
                                    input logic eq, input logic un);
    case (p)
      PRED_EQ: pred_hit = eq;
      PRED_LT: pred_hit = lt;
      PRED_LE: pred_hit = lt | eq;
      PRED_UNORD: pred_hit = un;
      PRED_NEQ: pred_hit = ~eq;
      PRED_NLT: pred_hit = ~lt;
      PRED_NLE: pred_hit = ~(lt | eq);
      default: pred_hit = ~un;
    endcase
  endfunction : pred_hit

  // One comparator per lane; lane 0 also feeds the flag compares
  for (genvar gi = 0; gi < LANES; gi++) begin : g_cmp
    ssfid_fcmp u_cmp (
      .a(d[gi*LANE_W +: LANE_W]),
      .b(s[gi*LANE_W +: LANE_W]),
      .lt(lane_lt[gi]),
      .eq(lane_eq[gi]),
      .unord(lane_un[gi]),
      .snan(lane_sn[gi])
    );
  end

  // Converter steering: scalar int source comes from the general register
  always_comb begin
    cvt_to_int = (REQ.op == OP_CVT_PACKED_SINGLE_TO_INT) ||
                 (REQ.op == OP_CVT_TRUNC_PACKED_SINGLE_TO_INT) ||
                 (REQ.op == OP_CVT_SCALAR_SINGLE_TO_INT) ||
                 (REQ.op == OP_CVT_TRUNC_SCALAR_SINGLE_TO_INT);
    cvt_trunc = (REQ.op == OP_CVT_TRUNC_PACKED_SINGLE_TO_INT) ||
                (REQ.op == OP_CVT_TRUNC_SCALAR_SINGLE_TO_INT);
    cvt_mode = cvt_trunc ? RC_ZERO : csr_reg[CSR_RC_LSB +: 2];
    cvt_in[0] = (REQ.op == OP_CVT_INT_TO_SCALAR_SINGLE) ? REQ.gpr : s[31:0];
    cvt_in[1] = s[63:32];
  end

  // Two converter lanes cover the packed doubleword pair
  for (genvar gi = 0; gi < 2; gi++) begin : g_cvt
    ssfid_fcvt u_cvt (
      .to_int(cvt_to_int),
      .mode(cvt_mode),
      .x(cvt_in[gi]),
      .y(cvt_out[gi]),
      .invalid(cvt_inv[gi])
    );
  end

  // Next answer and control register; data held between operations
  always_comb begin
    resp_next = resp_reg;
    resp_next.vec_we = 1'b0;
    resp_next.gpr_we = 1'b0;
    resp_next.flags_we = 1'b0;
    resp_next.mem_we = 1'b0;
    resp_next.invalid = 1'b0;
    valid_next = REQ_VALID;
    csr_next = csr_reg;
    keep_hi = 1'b0;
    idx = REQ.wide ? REQ.imm[2:0] : {1'b0, REQ.imm[1:0]};
    s9 = 9'h0;
    s17 = 17'h0;
    prod = 32'h0;
    mask = 16'h0;
    ab = 8'h0;
    bb = 8'h0;
    acc0 = 11'h0;
    acc1 = 11'h0;
    if (REQ_VALID) begin
      resp_next.vec = d;
      case (REQ.op)
        OP_CMP_PACKED_SINGLE: begin
          for (int i = 0; i < LANES; i++) begin
            resp_next.vec[i*LANE_W +: LANE_W] = {LANE_W{pred_hit(REQ.imm[2:0],
              lane_lt[i], lane_eq[i], lane_un[i])}};
          end
          resp_next.vec_we = 1'b1;
        end
        OP_CMP_SCALAR_SINGLE: begin
          // Upper three lanes stay as the destination had them
          resp_next.vec[31:0] = {LANE_W{pred_hit(REQ.imm[2:0],
            lane_lt[0], lane_eq[0], lane_un[0])}};
          resp_next.vec_we = 1'b1;
        end
        OP_ORDERED_CMP_FLAGS, OP_UNORDERED_CMP_FLAGS: begin
          if (lane_un[0]) begin
            resp_next.flags = 3'b111;
          end else if (lane_lt[0]) begin
            resp_next.flags = 3'b001;
          end else if (lane_eq[0]) begin
            resp_next.flags = 3'b100;
          end else begin
            resp_next.flags = 3'b000;
          end
          resp_next.flags_we = 1'b1;
          if (REQ.op == OP_ORDERED_CMP_FLAGS) begin
            resp_next.invalid = lane_un[0];
          end else begin
            resp_next.invalid = lane_sn[0];
          end
        end
        OP_SHUFFLE_PACKED_SINGLE: begin
          resp_next.vec = {s[32*REQ.imm[7:6] +: 32], s[32*REQ.imm[5:4] +: 32],
                           d[32*REQ.imm[3:2] +: 32],
                           d[32*REQ.imm[1:0] +: 32]};
          resp_next.vec_we = 1'b1;
        end
        OP_UNPACK_HIGH_SINGLE: begin
          resp_next.vec = {s[127:96], d[127:96], s[95:64], d[95:64]};
          resp_next.vec_we = 1'b1;
        end
        OP_UNPACK_LOW_SINGLE: begin
          resp_next.vec = {s[63:32], d[63:32], s[31:0], d[31:0]};
          resp_next.vec_we = 1'b1;
        end
        OP_CVT_PACKED_INT_TO_SINGLE: begin
          resp_next.vec = {d[127:64], cvt_out[1], cvt_out[0]};
          resp_next.vec_we = 1'b1;
        end
        OP_CVT_INT_TO_SCALAR_SINGLE: begin
          resp_next.vec = {d[127:32], cvt_out[0]};
          resp_next.vec_we = 1'b1;
        end
        OP_CVT_PACKED_SINGLE_TO_INT, OP_CVT_TRUNC_PACKED_SINGLE_TO_INT: begin
          // Result targets a 64-bit register; upper half reads zero
          resp_next.vec = {64'h0, cvt_out[1], cvt_out[0]};
          resp_next.invalid = |cvt_inv;
          resp_next.vec_we = 1'b1;
        end
        OP_CVT_SCALAR_SINGLE_TO_INT, OP_CVT_TRUNC_SCALAR_SINGLE_TO_INT: begin
          resp_next.gpr = cvt_out[0];
          resp_next.invalid = cvt_inv[0];
          resp_next.gpr_we = 1'b1;
        end
        OP_AVG_UNSIGNED_BYTE: begin
          for (int i = 0; i < 16; i++) begin
            s9 = {1'b0, d[8*i +: 8]} + {1'b0, s[8*i +: 8]} + 9'h1;
            resp_next.vec[8*i +: 8] = s9[8:1];
          end
          keep_hi = 1'b1;
        end
        OP_AVG_UNSIGNED_WORD: begin
          for (int i = 0; i < 8; i++) begin
            s17 = {1'b0, d[16*i +: 16]} + {1'b0, s[16*i +: 16]} + 17'h1;
            resp_next.vec[16*i +: 16] = s17[16:1];
          end
          keep_hi = 1'b1;
        end
        OP_EXTRACT_WORD: begin
          resp_next.gpr = {16'h0, s[16*idx +: 16]};
          resp_next.gpr_we = 1'b1;
        end
        OP_INSERT_WORD: begin
          resp_next.vec[16*idx +: 16] = REQ.gpr[15:0];
          keep_hi = 1'b1;
        end
        OP_MAX_UNSIGNED_BYTE, OP_MIN_UNSIGNED_BYTE: begin
          for (int i = 0; i < 16; i++) begin
            ab = d[8*i +: 8];
            bb = s[8*i +: 8];
            if ((ab > bb) == (REQ.op == OP_MAX_UNSIGNED_BYTE)) begin
              resp_next.vec[8*i +: 8] = ab;
            end else begin
              resp_next.vec[8*i +: 8] = bb;
            end
          end
          keep_hi = 1'b1;
        end
        OP_MAX_SIGNED_WORD, OP_MIN_SIGNED_WORD: begin
          for (int i = 0; i < 8; i++) begin
            if (($signed(d[16*i +: 16]) > $signed(s[16*i +: 16])) ==
                (REQ.op == OP_MAX_SIGNED_WORD)) begin
              resp_next.vec[16*i +: 16] = d[16*i +: 16];
            end else begin
              resp_next.vec[16*i +: 16] = s[16*i +: 16];
            end
          end
          keep_hi = 1'b1;
        end
        OP_BYTE_SIGN_MASK: begin
          for (int i = 0; i < 16; i++) begin
            mask[i] = s[8*i + 7];
          end
          resp_next.gpr = REQ.wide ? {16'h0, mask}
                                   : {24'h0, mask[7:0]};
          resp_next.gpr_we = 1'b1;
        end
        OP_MUL_HIGH_UNSIGNED_WORD: begin
          for (int i = 0; i < 8; i++) begin
            prod = d[16*i +: 16] * s[16*i +: 16];
            resp_next.vec[16*i +: 16] = prod[31:16];
          end
          keep_hi = 1'b1;
        end
        OP_SUM_ABS_DIFF_BYTE: begin
          // Wide: each quadword sums into its own low word, rest zero; narrow: low quadword only
          for (int i = 0; i < 8; i++) begin
            ab = d[8*i +: 8];
            bb = s[8*i +: 8];
            acc0 = acc0 + {3'h0, (ab > bb) ? (ab - bb) : (bb - ab)};
            ab = d[64 + 8*i +: 8];
            bb = s[64 + 8*i +: 8];
            acc1 = acc1 + {3'h0, (ab > bb) ? (ab - bb) : (bb - ab)};
          end
          resp_next.vec = {53'h0, acc1, 53'h0, acc0};
          keep_hi = 1'b1;
        end
        OP_SHUFFLE_WORD: begin
          for (int i = 0; i < 4; i++) begin
            resp_next.vec[16*i +: 16] =
              s[16*REQ.imm[2*i +: 2] +: 16];
          end
          resp_next.vec_we = 1'b1;
        end
        OP_LOAD_VECTOR_CSR: begin
          csr_next = REQ.mem;
        end
        OP_STORE_VECTOR_CSR: begin
          resp_next.mem_data = csr_reg;
          resp_next.mem_we = 1'b1;
        end
        default: begin
          resp_next.vec = resp_reg.vec;
        end
      endcase
      // Narrow integer forms leave the upper quadword alone
      if (keep_hi) begin
        resp_next.vec_we = 1'b1;
        if (!REQ.wide) begin
          resp_next.vec[127:64] = d[127:64];
        end
      end
    end
  end

  // State registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      resp_reg <= '0;
      valid_reg <= 1'b0;
      csr_reg <= CSR_RESET;
    end else begin
      resp_reg <= resp_next;
      valid_reg <= valid_next;
      csr_reg <= csr_next;
    end
  end

  assign RESP = resp_reg;
  assign RESP_VALID = valid_reg;
  assign CSR_VALUE = csr_reg;

endmodule : ssfid_datapath
`default_nettype wire

// file: test/ssfid_datapath_checker.sv
// Port assertions for the single-float and packed-integer datapath
`default_nettype none
module ssfid_datapath_checker (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Issue and writeback
  input wire logic REQ_VALID,
  input wire ssfid_pkg::ssfid_req_t REQ,
  input wire logic RESP_VALID,
  input wire ssfid_pkg::ssfid_resp_t RESP,
  input wire logic [ssfid_pkg::CSR_W-1:0] CSR_VALUE
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssfid_pkg::*;
  ssfid_req_t q_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // Copy of the taken request, so answers compare against their cause
  always_ff @(posedge CLK) q_reg <= REQ;

  function automatic logic is_nan(input logic [31:0] v);
    return (&v[30:23]) && (|v[22:0]);
  endfunction : is_nan

  function automatic logic all_masks(input logic [127:0] v);
    all_masks = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[32*i+:32] != 32'h0 && v[32*i+:32] != 32'hffffffff) begin
        all_masks = 1'b0;
      end
    end
  endfunction : all_masks

  chk_answer_next: assert property (REQ_VALID |=> RESP_VALID)
    else $error("no answer one cycle after request");
  chk_no_spurious: assert property (!REQ_VALID |=>
    !RESP_VALID && !RESP.vec_we && !RESP.gpr_we && !RESP.mem_we)
    else $error("answer without request");
  chk_lane_masks: assert property (
    REQ_VALID && REQ.op == OP_CMP_PACKED_SINGLE |=> all_masks(RESP.vec))
    else $error("compare lane is not a full mask");
  chk_scalar_keep: assert property (
    REQ_VALID && REQ.op inside {OP_CMP_SCALAR_SINGLE,
    OP_CVT_INT_TO_SCALAR_SINGLE} |=> RESP.vec[127:32] == q_reg.dst[127:32])
    else $error("scalar op disturbed upper lanes");
  chk_unpack_low: assert property (
    REQ_VALID && REQ.op == OP_UNPACK_LOW_SINGLE |=> RESP.vec ==
    {q_reg.src[63:32], q_reg.dst[63:32], q_reg.src[31:0], q_reg.dst[31:0]})
    else $error("low unpack order wrong");
  chk_unpack_high: assert property (
    REQ_VALID && REQ.op == OP_UNPACK_HIGH_SINGLE |=> RESP.vec ==
    {q_reg.src[127:96], q_reg.dst[127:96], q_reg.src[95:64],
    q_reg.dst[95:64]})
    else $error("high unpack order wrong");
  chk_csr_load: assert property (
    REQ_VALID && REQ.op == OP_LOAD_VECTOR_CSR |=> CSR_VALUE == q_reg.mem)
    else $error("control register load lost");
  chk_csr_hold: assert property (
    !(REQ_VALID && REQ.op == OP_LOAD_VECTOR_CSR) |=> $stable(CSR_VALUE))
    else $error("control register changed without load");
  chk_csr_store: assert property (
    REQ_VALID && REQ.op == OP_STORE_VECTOR_CSR |=>
    RESP.mem_we && RESP.mem_data == CSR_VALUE)
    else $error("control register store wrong");
  chk_avg_byte: assert property (
    REQ_VALID && REQ.op == OP_AVG_UNSIGNED_BYTE |=> RESP.vec[7:0] ==
    (({1'b0, q_reg.dst[7:0]} + q_reg.src[7:0] + 9'h1) >> 1))
    else $error("byte average wrong");
  chk_flag_unord: assert property (
    REQ_VALID && REQ.op inside {OP_ORDERED_CMP_FLAGS,
    OP_UNORDERED_CMP_FLAGS} && (is_nan(REQ.dst[31:0]) ||
    is_nan(REQ.src[31:0])) |=> RESP.flags_we && RESP.flags == 3'h7)
    else $error("unordered flags wrong");
  chk_ordered_inv: assert property (
    REQ_VALID && REQ.op == OP_ORDERED_CMP_FLAGS && (is_nan(REQ.dst[31:0])
    || is_nan(REQ.src[31:0])) |=> RESP.invalid)
    else $error("ordered compare missed invalid");

  // Main scenarios reached
  cov_load: cover property (REQ_VALID && REQ.op == OP_LOAD_VECTOR_CSR);
  cov_cmp: cover property (REQ_VALID && REQ.op == OP_CMP_PACKED_SINGLE);
  cov_inv: cover property (RESP_VALID && RESP.invalid);
endmodule : ssfid_datapath_checker

bind ssfid_datapath ssfid_datapath_checker u_ssfid_datapath_checker (
  .CLK(CLK), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ(REQ),
  .RESP_VALID(RESP_VALID), .RESP(RESP), .CSR_VALUE(CSR_VALUE));
`default_nettype wire

// file: test/ssfid_issue_model.sv
// Issue-side model: presents one request and collects its answer
`default_nettype none
module ssfid_issue_model (
  // Clock
  input wire logic clk,
  // Request out
  output logic req_valid,
  output var ssfid_pkg::ssfid_req_t req,
  // Answer in
  input wire logic resp_valid,
  input wire ssfid_pkg::ssfid_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssfid_pkg::*;

  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // One-cycle strobe; the idle bus is scrambled so stale data never helps
  task automatic issue(input ssfid_req_t q, output ssfid_resp_t a,
                       output logic ok);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= q;
    @(posedge clk);
    req_valid <= 1'b0;
    req <= ssfid_req_t'(~q);
    ok = 1'b0;
    for (int n = 0; n < 3 && !ok; n++) begin
      #1;
      ok = (resp_valid === 1'b1);
      if (!ok) @(posedge clk);
    end
    a = resp;
  endtask : issue
endmodule : ssfid_issue_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the single-float and packed-integer datapath
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssfid_pkg::*;
  localparam logic [127:0] FD = 128'h40000000_7fc00000_40000000_3f800000;
  localparam logic [127:0] FS = 128'h40000000_3f800000_3f800000_40000000;
  localparam logic [127:0] SD = 128'h33333333_22222222_11111111_00000000;
  localparam logic [127:0] SS = 128'h77777777_66666666_55555555_44444444;
  localparam logic [127:0] IA = 128'h0123456789abcdef_80ff00017fff8000;
  localparam logic [127:0] IB = 128'hfedcba9876543210_7f01ff0080017fff;
  localparam logic [127:0] HALF = 128'hc0200000_40200000;
  logic CLK, RESET, req_valid, resp_valid;
  ssfid_req_t req;
  ssfid_resp_t resp, r;
  logic [CSR_W-1:0] csr_value;
  int err_count = 0;
  int checks = 0;
  int pos [4] = '{2, 2, 3, 2};
  int neg [4] = '{-2, -3, -2, -2};

  ssfid_datapath u_ssfid_datapath (.CLK(CLK), .RESET(RESET),
    .REQ_VALID(req_valid), .REQ(req), .RESP_VALID(resp_valid),
    .RESP(resp), .CSR_VALUE(csr_value));
  ssfid_issue_model u_issue_model (.clk(CLK), .req_valid(req_valid),
    .req(req), .resp_valid(resp_valid), .resp(resp));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task end_of_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task ck(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : ck

  // One operation; a missing answer ends the run
  task automatic t(input ssfid_op_t op, input logic [7:0] imm,
                   input logic w, input logic [127:0] d,
                   input logic [127:0] s, input logic [31:0] x);
    logic ok;
    u_issue_model.issue('{op, imm, w, d, s, x, x}, r, ok);
    if (ok !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask : t

  // Predicate truth for lane relations less, equal, unordered
  function automatic logic pt(input logic [2:0] p, input logic l,
                              input logic e, input logic u);
    logic [7:0] v;
    v = {~u, ~(l | e), ~l, ~e, u, l | e, l, e};
    return v[p];
  endfunction : pt

  task automatic fc(input ssfid_op_t op, input logic [31:0] a,
                    input logic [31:0] b, input logic [2:0] fl,
                    input logic inv);
    t(op, 0, 0, {96'h0, a}, {96'h0, b}, 0);
    ck({r.flags_we, r.flags, r.invalid}, {1'b1, fl, inv});
  endtask : fc

  initial begin
    RESET = 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    ck(csr_value, CSR_RESET);
    // Lanes: less, greater, unordered, equal under every predicate
    for (int p = 0; p < 8; p++) begin
      t(OP_CMP_PACKED_SINGLE, 8'(p), 0, FD, FS, 0);
      ck(r.vec, {{32{pt(3'(p), 0, 1, 0)}}, {32{pt(3'(p), 0, 0, 1)}},
        {32{pt(3'(p), 0, 0, 0)}}, {32{pt(3'(p), 1, 0, 0)}}});
    end
    t(OP_CMP_SCALAR_SINGLE, {5'h0, PRED_NLE}, 0, FD, FS, 0);
    ck(r.vec, {FD[127:32], 32'h0});
    fc(OP_ORDERED_CMP_FLAGS, 32'h3f800000, 32'h40000000, 3'h1, 0);
    fc(OP_ORDERED_CMP_FLAGS, 32'h40000000, 32'h3f800000, 3'h0, 0);
    fc(OP_UNORDERED_CMP_FLAGS, 32'h40000000, 32'h40000000, 3'h4, 0);
    fc(OP_UNORDERED_CMP_FLAGS, 32'h7fc00000, 32'h3f800000, 3'h7, 0);
    fc(OP_ORDERED_CMP_FLAGS, 32'h7fc00000, 32'h3f800000, 3'h7, 1);
    fc(OP_UNORDERED_CMP_FLAGS, 32'h3f800000, 32'h7f800001, 3'h7, 1);
    // Shuffles and interleaves on distinct lane patterns
    t(OP_SHUFFLE_PACKED_SINGLE, 8'h1b, 0, SD, SS, 0);
    ck(r.vec, 128'h44444444_55555555_22222222_33333333);
    t(OP_SHUFFLE_PACKED_SINGLE, 8'he4, 0, SD, SS, 0);
    ck(r.vec, 128'h77777777_66666666_11111111_00000000);
    t(OP_UNPACK_HIGH_SINGLE, 0, 0, SD, SS, 0);
    ck(r.vec, 128'h77777777_33333333_66666666_22222222);
    t(OP_UNPACK_LOW_SINGLE, 0, 0, SD, SS, 0);
    ck(r.vec, 128'h55555555_11111111_44444444_00000000);
    // Every rounding mode, loaded then stored back
    for (int m = 0; m < 4; m++) begin
      t(OP_LOAD_VECTOR_CSR, 0, 0, 0, 0, 32'(m) << CSR_RC_LSB);
      ck(csr_value, 32'(m) << CSR_RC_LSB);
      t(OP_STORE_VECTOR_CSR, 0, 0, 0, 0, 0);
      ck({r.mem_we, r.mem_data}, {1'b1, 32'(m) << CSR_RC_LSB});
      t(OP_CVT_PACKED_SINGLE_TO_INT, 0, 0, FD, HALF, 0);
      ck(r.vec, {64'h0, 32'(neg[m]), 32'(pos[m])});
      t(OP_CVT_SCALAR_SINGLE_TO_INT, 0, 0, FD, HALF, 0);
      ck({r.gpr_we, r.gpr}, {1'b1, 32'(pos[m])});
      t(OP_CVT_TRUNC_PACKED_SINGLE_TO_INT, 0, 0, FD, HALF, 0);
      ck(r.vec, {64'h0, 32'hfffffffe, 32'h2});
      t(OP_CVT_TRUNC_SCALAR_SINGLE_TO_INT, 0, 0, FD, HALF >> 32, 0);
      ck(r.gpr, 32'hfffffffe);
      t(OP_CVT_INT_TO_SCALAR_SINGLE, 0, 0, FD, 0, 32'h01000001);
      ck(r.vec, {FD[127:32], 32'h4b800000 + 32'(m == RC_UP)});
      t(OP_CVT_PACKED_INT_TO_SINGLE, 0, 0, FD, 64'hffffffff01000001, 0);
      ck(r.vec, {FD[127:64], 32'hbf800000,
        32'h4b800000 + 32'(m == RC_UP)});
    end
    t(OP_CVT_PACKED_SINGLE_TO_INT, 0, 0, FD, 64'hcf000000_4f000000, 0);
    ck({r.invalid, r.vec[63:0]}, {1'b1, 64'h80000000_80000000});
    t(OP_CVT_SCALAR_SINGLE_TO_INT, 0, 0, FD, 32'hcf000000, 0);
    ck({r.invalid, r.gpr}, {1'b0, 32'h80000000});
    t(OP_NOP, 0, 0, IA, IB, 0);
    ck({r.vec_we, r.gpr_we, r.flags_we, r.mem_we}, 4'h0);
    // Integer element operations, narrow unless marked wide
    t(OP_AVG_UNSIGNED_BYTE, 0, 0, IA, IB, 0);
    ck({r.vec[127:64], r.vec[15:0]}, {IA[127:64], 16'h8080});
    t(OP_AVG_UNSIGNED_WORD, 0, 0, IA, IB, 0);
    ck(r.vec[31:0], 32'h80008000);
    t(OP_MAX_UNSIGNED_BYTE, 0, 0, IA, IB, 0);
    ck(r.vec[15:0], 16'h80ff);
    t(OP_MIN_UNSIGNED_BYTE, 0, 0, IA, IB, 0);
    ck(r.vec[15:0], 16'h7f00);
    t(OP_MAX_SIGNED_WORD, 0, 0, IA, IB, 0);
    ck(r.vec[31:0], 32'h7fff7fff);
    t(OP_MIN_SIGNED_WORD, 0, 0, IA, IB, 0);
    ck(r.vec[31:0], 32'h80018000);
    t(OP_MUL_HIGH_UNSIGNED_WORD, 0, 0, IA, IB, 0);
    ck(r.vec[63:0], 64'h3fff00003fff3fff);
    t(OP_SUM_ABS_DIFF_BYTE, 0, 0, IA, IB, 0);
    ck(r.vec[63:0], 64'h3fe);
    t(OP_BYTE_SIGN_MASK, 0, 0, IA, IB, 0);
    ck({r.gpr_we, r.gpr}, {1'b1, 32'h29});
    t(OP_BYTE_SIGN_MASK, 0, 1, IA, IB, 0);
    ck(r.gpr, 32'hf029);
    t(OP_SHUFFLE_WORD, 8'h1b, 0, IB, IA, 0);
    ck(r.vec, {IB[127:64], 64'h80007fff000180ff});
    ck(r.vec_we, 1'b1);
    t(OP_EXTRACT_WORD, 8'h3, 0, IB, IA, 0);
    ck({r.gpr_we, r.gpr}, {1'b1, 32'h80ff});
    t(OP_EXTRACT_WORD, 8'h5, 1, IB, IA, 0);
    ck(r.gpr, 32'h89ab);
    t(OP_INSERT_WORD, 8'h2, 0, IA, IB, 32'h0000beef);
    ck(r.vec, {IA[127:64], 64'h80ffbeef7fff8000});
    // Reset in mid-run returns the control register to its reset value
    @(posedge CLK);
    RESET <= 1'b1;
    @(posedge CLK);
    ck(csr_value, CSR_RESET);
    ck(resp_valid, 1'b0);
    ck(resp.vec, 128'h0);
    RESET <= 1'b0;
    t(OP_CVT_SCALAR_SINGLE_TO_INT, 0, 0, FD, 32'h40600000, 0);
    ck(r.gpr, 32'h4);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
